//--- itr_map.vh
// register offsets, field layout and timing constants of the request router
`ifndef ITR_MAP_VH
`define ITR_MAP_VH
`define ITR_NSRC 8
`define ITR_OFF_DTE 8'h00
`define ITR_OFF_CPU_INTERRUPT_SELECT_BIT 8'h04
`define ITR_OFF_FLAG 8'h08
`define ITR_OFF_FCLR 8'h0c
`define ITR_OFF_STAT 8'h10
`define ITR_OFF_SCLR 8'h14
`define ITR_OFF_IEN 8'h18
`define ITR_OFF_EXT 8'h1c
`define ITR_OFF_RESP 8'h20
`define ITR_RST_BYTE 8'h00
`define ITR_RST_WORD 32'h0000_0000
`define ITR_EV_XEND 0
`define ITR_EV_CPUREQ 1
`define ITR_EV_NUM 2
`define ITR_MIN_PERIPH 4'ha
`define ITR_MIN_EXT 4'hc
`define ITR_MAX_PERIPH 4'hc
`define ITR_MAX_EXT 4'hd
`define ITR_CNT_W 8
`define ITR_ONE_CNT 8'h01
`define ITR_ZERO_CNT 8'h00
`define ITR_HTRANS_NONSEQ_BIT 1
`define ITR_HSIZE_WORD 3'h2
`endif

//--- itr_resp_timer.v
// response timer: holds the cpu request for the documented least number of states
`timescale 1ns/10ps
`include "itr_map.vh"
module itr_resp_timer (
	input wire hclk,
	input wire hresetn,
	input wire req_in,
	input wire is_ext,
	output reg req_out,
	output reg [7:0] last_lat
);
	reg [7:0] cnt_r;
	reg busy_r;
	wire [7:0] min_states;
	// least response time depends on source kind
	assign min_states = is_ext ? {4'h0, `ITR_MIN_EXT} : {4'h0, `ITR_MIN_PERIPH};
	// count states from request until the request is presented to the cpu
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cnt_r <= `ITR_ZERO_CNT;
			busy_r <= 1'b0;
			req_out <= 1'b0;
			last_lat <= `ITR_ZERO_CNT;
		end else if (!req_in) begin
			cnt_r <= `ITR_ZERO_CNT;
			busy_r <= 1'b0;
			req_out <= 1'b0;
		end else if (!busy_r) begin
			busy_r <= 1'b1;
			cnt_r <= `ITR_ONE_CNT;
		end else if (!req_out) begin
			cnt_r <= cnt_r + `ITR_ONE_CNT;
			if (cnt_r + `ITR_ONE_CNT >= min_states) begin
				req_out <= 1'b1;
				last_lat <= cnt_r + `ITR_ONE_CNT;
			end
		end
	end
endmodule // itr_resp_timer

//--- itr_router.v
// interrupt and transfer request router with ahb-lite register slave
//
// The implementer's own choices: the AHB-Lite slave port and the register offsets.
`timescale 1ns/10ps
`include "itr_map.vh"

module itr_router (
	input wire hclk,
	input wire hresetn,
	input wire hsel,
	input wire [7:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [2:0] hsize,
	input wire [31:0] hwdata,
	input wire hready,
	output reg [31:0] hrdata,
	output wire hreadyout,
	output wire hresp,
	input wire [7:0] src_event,
	input wire [7:0] ext_pin,
	input wire xfer_end,
	input wire [2:0] xfer_src,
	input wire cnt_zero,
	output reg [7:0] xfer_req,
	output wire cpu_irq,
	output wire [7:0] cpu_src,
	output wire irq
);
	// control bits, source flags and status
	reg [7:0] dte_r;
	reg [7:0] cpu_interrupt_select_bit_r;
	reg [7:0] flag_r;
	reg [7:0] ext_r;
	reg [1:0] stat_r;
	reg [1:0] ien_r;

	// pin synchronisers and edge history
	reg [7:0] pin_s1_r;
	reg [7:0] pin_s2_r;
	reg [7:0] pin_d_r;
	reg [7:0] src_d_r;

	// registered address phase
	reg wr_r;
	reg [7:0] wa_r;
	reg rd_r;
	reg [7:0] ra_r;

	// next-state and decode terms
	reg [7:0] dte_nxt;
	reg [7:0] flag_nxt;
	reg [7:0] end_hot;
	reg clr_term;
	reg [31:0] rd_nxt;

	// combinational routing terms
	wire [7:0] pin_rise;
	wire [7:0] new_ev;
	wire [7:0] cpu_pend;
	wire any_cpu;
	wire any_ext;
	wire timed_req;
	wire [7:0] lat;
	wire acc;
	// per-register write strobes of the data phase
	wire wr_dte;
	wire wr_cpu_interrupt_select_bit;
	wire wr_fclr;
	wire wr_sclr;
	wire wr_ien;
	wire wr_ext;
	integer i;

	// one-hot decode of a source index
	function [7:0] onehot;
		input [2:0] idx;
		begin
			onehot = 8'h01 << idx;
		end
	endfunction

	// offset compare used by both write and read paths
	function hit;
		input [7:0] a;
		input [7:0] off;
		begin
			hit = (a == off);
		end
	endfunction

	// external pins pass two flops before edge detection
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pin_s1_r <= `ITR_RST_BYTE;
			pin_s2_r <= `ITR_RST_BYTE;
			pin_d_r <= `ITR_RST_BYTE;
			src_d_r <= `ITR_RST_BYTE;
		end else begin
			pin_s1_r <= ext_pin;
			pin_s2_r <= pin_s1_r;
			pin_d_r <= pin_s2_r;
			src_d_r <= src_event;
		end
	end

	// rising edge of the synchronised pins
	assign pin_rise = pin_s2_r & ~pin_d_r;
	// rising peripheral events and pin edges set source flags
	assign new_ev = (src_event & ~src_d_r) | (pin_rise & ext_r);

	// ahb address phase capture
	assign acc = hsel & hready & htrans[`ITR_HTRANS_NONSEQ_BIT];
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_r <= 1'b0;
			rd_r <= 1'b0;
			wa_r <= `ITR_RST_BYTE;
			ra_r <= `ITR_RST_BYTE;
		end else begin
			wr_r <= acc & hwrite;
			rd_r <= acc & ~hwrite;
			wa_r <= haddr;
			ra_r <= haddr;
		end
	end

	// zero wait states, always an okay response
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;

	// write strobes decoded once for all writable registers; flag, status and response have none
	assign wr_dte = wr_r & hit(wa_r, `ITR_OFF_DTE);
	assign wr_cpu_interrupt_select_bit = wr_r & hit(wa_r, `ITR_OFF_CPU_INTERRUPT_SELECT_BIT);
	assign wr_fclr = wr_r & hit(wa_r, `ITR_OFF_FCLR);
	assign wr_sclr = wr_r & hit(wa_r, `ITR_OFF_SCLR);
	assign wr_ien = wr_r & hit(wa_r, `ITR_OFF_IEN);
	assign wr_ext = wr_r & hit(wa_r, `ITR_OFF_EXT);

	// enable clear term and end-of-transfer decode
	always @* begin
		end_hot = xfer_end ? onehot(xfer_src) : `ITR_RST_BYTE;
		clr_term = cpu_interrupt_select_bit_r[xfer_src] | cnt_zero;
		dte_nxt = dte_r;
		flag_nxt = flag_r;
		// software writes first, hardware events win afterwards
		if (wr_dte) begin
			dte_nxt = hwdata[7:0];
		end
		if (wr_fclr) begin
			flag_nxt = flag_nxt & ~hwdata[7:0];
		end
		if (clr_term) begin
			dte_nxt = dte_nxt & ~end_hot;
		end else begin
			flag_nxt = flag_nxt & ~end_hot;
		end
		// flag stays set in combined mode; new events win over clears
		flag_nxt = flag_nxt | new_ev;
	end

	// control registers and source flags
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dte_r <= `ITR_RST_BYTE;
			cpu_interrupt_select_bit_r <= `ITR_RST_BYTE;
			flag_r <= `ITR_RST_BYTE;
			ext_r <= `ITR_RST_BYTE;
			ien_r <= {`ITR_EV_NUM{1'b0}};
		end else begin
			dte_r <= dte_nxt;
			flag_r <= flag_nxt;
			if (wr_cpu_interrupt_select_bit) begin
				cpu_interrupt_select_bit_r <= hwdata[7:0];
			end
			if (wr_ext) begin
				ext_r <= hwdata[7:0];
			end
			if (wr_ien) begin
				ien_r <= hwdata[`ITR_EV_NUM-1:0];
			end
		end
	end

	// activation requests to the transfer controller, one per source
	genvar g;
	generate
		for (g = 0; g < `ITR_NSRC; g = g + 1) begin : g_req
			always @(posedge hclk or negedge hresetn) begin
				if (!hresetn) begin
					xfer_req[g] <= 1'b0;
				end else begin
					xfer_req[g] <= flag_nxt[g] & dte_nxt[g];
				end
			end
		end
	endgenerate

	// cpu path masked while the enable bit is armed
	assign cpu_pend = flag_r & ~dte_r;
	assign cpu_src = cpu_pend;
	assign any_cpu = |cpu_pend;
	assign any_ext = |(cpu_pend & ext_r);

	// response timing towards the cpu; longer waits belong to the cpu side
	itr_resp_timer u_timer (
		.hclk(hclk),
		.hresetn(hresetn),
		.req_in(any_cpu),
		.is_ext(any_ext),
		.req_out(timed_req),
		.last_lat(lat)
	);
	assign cpu_irq = timed_req;

	// sticky status: transfer end and cpu request raised
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			stat_r <= {`ITR_EV_NUM{1'b0}};
		end else begin
			// clears first so a same-cycle set wins
			for (i = 0; i < `ITR_EV_NUM; i = i + 1) begin
				if (wr_sclr && hwdata[i]) begin
					stat_r[i] <= 1'b0;
				end
			end
			if (xfer_end) begin
				stat_r[`ITR_EV_XEND] <= 1'b1;
			end
			if (timed_req) begin
				stat_r[`ITR_EV_CPUREQ] <= 1'b1;
			end
		end
	end

	// level interrupt while an enabled status bit is set
	assign irq = |(stat_r & ien_r);

	// read mux in data phase
	always @* begin
		rd_nxt = `ITR_RST_WORD;
		if (hit(ra_r, `ITR_OFF_DTE)) begin
			rd_nxt[7:0] = dte_r;
		end else if (hit(ra_r, `ITR_OFF_CPU_INTERRUPT_SELECT_BIT)) begin
			rd_nxt[7:0] = cpu_interrupt_select_bit_r;
		end else if (hit(ra_r, `ITR_OFF_FLAG)) begin
			rd_nxt[7:0] = flag_r;
		end else if (hit(ra_r, `ITR_OFF_STAT)) begin
			rd_nxt[`ITR_EV_NUM-1:0] = stat_r;
		end else if (hit(ra_r, `ITR_OFF_IEN)) begin
			rd_nxt[`ITR_EV_NUM-1:0] = ien_r;
		end else if (hit(ra_r, `ITR_OFF_EXT)) begin
			rd_nxt[7:0] = ext_r;
		end else if (hit(ra_r, `ITR_OFF_RESP)) begin
			rd_nxt[7:0] = lat;
		end
	end

	// read data only in a read data phase
	always @* begin
		hrdata = rd_r ? rd_nxt : `ITR_RST_WORD;
	end
endmodule // itr_router

//--- itr_chk_props.sv
// port assertions of the request router
`timescale 1ns/10ps
module itr_chk (
	input wire hclk,
	input wire hresetn,
	input wire hreadyout,
	input wire hresp,
	input wire [7:0] src_event,
	input wire xfer_end,
	input wire [2:0] xfer_src,
	input wire cnt_zero,
	input wire [7:0] xfer_req,
	input wire [7:0] cpu_src,
	input wire cpu_irq
);
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	// any source pending on either route
	wire pend = |(xfer_req | cpu_src);
	bus_okay_a: assert property (hreadyout && !hresp) else $error("bus not ready");
	route_excl_a: assert property ((xfer_req & cpu_src) == 8'h00) else $error("both routes");
	event_route_a: assert property ($rose(|src_event) && !pend |-> ##[1:3] pend) else $error("lost");
	end_drop_a: assert property (xfer_end |=> !xfer_req[$past(xfer_src)]) else $error("req held");
	zero_cpu_a: assert property (xfer_end && cnt_zero |=> cpu_src[$past(xfer_src)]) else $error("no cpu");
	resp_min_a: assert property ($rose(|cpu_src) && !cpu_irq |-> !cpu_irq [*8] ##1 !cpu_irq ##1 !cpu_irq ##[1:3] cpu_irq)
		else $error("response time");
	irq_drop_a: assert property (!(|cpu_src) |-> ##[0:1] !cpu_irq) else $error("irq stuck");
	req_hold_a: assert property (|xfer_req && !xfer_end |=> |xfer_req) else $error("req lost");
endmodule // itr_chk

//--- itr_xfer_model.sv
// transfer controller model
`timescale 1ns/10ps
module itr_xfer_model (
	input wire hclk,
	input wire hresetn,
	input wire [7:0] xfer_req,
	input wire [1:0] dly,
	input wire load,
	input wire [7:0] cnt,
	output reg xfer_end,
	output reg [2:0] xfer_src,
	output reg cnt_zero
);
	reg [7:0] left_r;
	reg [1:0] wait_r;
	integer i;
	// one transfer per request after a delay
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			{xfer_end, xfer_src, cnt_zero, left_r, wait_r} <= 15'h0;
		end else if (xfer_end) begin
			xfer_end <= 1'b0;
			xfer_src <= ~xfer_src; // released lines toggle
			cnt_zero <= ~cnt_zero;
			wait_r <= dly;
		end else if (load) begin
			left_r <= cnt;
		end else if (|xfer_req) begin
			if (wait_r != 2'h0) begin
				wait_r <= wait_r - 2'h1;
			end else begin
				for (i = 7; i >= 0; i = i - 1)
					if (xfer_req[i]) xfer_src <= i[2:0];
				xfer_end <= 1'b1;
				cnt_zero <= (left_r == 8'h01);
				left_r <= left_r - 8'h01;
			end
		end
	end
endmodule // itr_xfer_model

//--- testbench.sv
// self-checking bench of the request router
`timescale 1ns/10ps
module testbench;
	reg hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, load = 1'b0;
	reg [7:0] haddr = 8'h00, src_event = 8'h00, cnt = 8'h00, ext_pin = 8'h00;
	reg [1:0] htrans = 2'h0, dly = 2'h0;
	reg [31:0] hwdata = 32'h0, r;
	wire [31:0] hrdata;
	wire hreadyout, hresp, xfer_end, cnt_zero, cpu_irq, irq;
	wire [2:0] xfer_src;
	wire [7:0] xfer_req, cpu_src;
	integer seed = 32'hdd07, miscompares = 0, comparisons = 0, n, k, m, s, e, xp;
	itr_router uut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
		.hready(hreadyout), .hrdata, .hreadyout, .hresp, .src_event, .ext_pin, .xfer_end,
		.xfer_src, .cnt_zero, .xfer_req, .cpu_irq, .cpu_src, .irq);
	itr_xfer_model tcm (.hclk, .hresetn, .xfer_req, .dly, .load, .cnt, .xfer_end, .xfer_src,
		.cnt_zero);
	// clock and watchdog
	initial forever #25 hclk = ~hclk;
	initial begin
		#1000000 miscompares = miscompares + 1;
		complete_run;
	end
	// expected status: end and cpu request bits
	function [31:0] stat_of(input integer md);
		stat_of = (md != 0) ? 32'h3 : 32'h2;
	endfunction
	task chk(input [31:0] got, input [31:0] exp);
		comparisons = comparisons + 1;
		if (got !== exp)
			$display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
		if (got !== exp) miscompares = miscompares + 1;
	endtask
	// one single ahb-lite transfer
	task bus(input w, input [7:0] a, input [31:0] d);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= w;
		@(posedge hclk);
		while (!hreadyout) @(posedge hclk);
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= d;
		@(posedge hclk);
		while (!hreadyout) @(posedge hclk);
		r = hrdata;
	endtask
	task rd(input [7:0] a, input [31:0] exp);
		bus(1'b0, a, 32'h0);
		chk(r, exp);
	endtask
	task complete_run;
		if (miscompares == 0 && comparisons > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// modes: cpu only, combined, transfer to zero, transfer twice
	initial begin
		repeat (4) @(posedge hclk);
		hresetn <= 1'b1;
		rd(8'hfc, 32'h0);
		for (n = 0; n < 12; n = n + 1) begin
			m = n % 4;
			xp = (m == 0 && n > 3);
			s = $random(seed) & 7;
			dly <= $random(seed) & 3;
			cnt <= (m == 1 || m == 3) ? 8'h02 : 8'h01;
			load <= 1'b1;
			@(posedge hclk);
			load <= 1'b0;
			bus(1'b1, 8'h1c, xp ? 32'h1 << s : 32'h0);
			bus(1'b1, 8'h04, m == 1 ? 32'h1 << s : 32'h0);
			bus(1'b1, 8'h00, m != 0 ? 32'h1 << s : 32'h0);
			for (e = (m == 3); e >= 0; e = e - 1) begin
				if (xp) ext_pin <= 8'h01 << s;
				else src_event <= 8'h01 << s;
				@(posedge hclk);
				src_event <= 8'h00;
				ext_pin <= 8'h00;
				for (k = 0; k < 60 && !(e ? xfer_end : cpu_irq); k = k + 1) @(posedge hclk);
				if (e) begin
					repeat (3) @(posedge hclk);
					chk(cpu_src, 32'h0);
					rd(8'h08, 32'h0);
					rd(8'h00, 32'h1 << s);
				end
			end
			chk(cpu_irq, 32'h1);
			chk(cpu_src, 32'h1 << s);
			rd(8'h00, 32'h0);
			rd(8'h08, 32'h1 << s);
			rd(8'h10, stat_of(m));
			rd(8'h20, xp ? 32'hc : 32'ha);
			bus(1'b1, 8'h18, 32'h0);
			@(negedge hclk) chk(irq, 32'h0);
			bus(1'b1, 8'h18, 32'h2);
			@(negedge hclk) chk(irq, 32'h1);
			bus(1'b1, 8'h0c, 32'h1 << s);
			bus(1'b1, 8'h14, 32'h3);
			rd(8'h10, 32'h0);
			@(negedge hclk) chk(irq, 32'h0);
			if (m == 1) bus(1'b1, 8'h00, 32'h1 << s);
		end
		complete_run;
	end
endmodule // testbench
bind itr_router itr_chk chk (.hclk, .hresetn, .hreadyout, .hresp, .src_event, .xfer_end, .xfer_src,
	.cnt_zero, .xfer_req, .cpu_src, .cpu_irq);
